/* design/dtp_pkg.sv */
package dtp_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_COUNT = 6'h10;
  localparam logic [5:0] IDX_CTL1 = 6'h11;
  localparam logic [5:0] IDX_CTL2 = 6'h12;
  localparam logic [5:0] IDX_DUTY = 6'h13;
  localparam logic [5:0] IDX_PSCV = 6'h14;
  localparam logic [5:0] IDX_BUZZ = 6'h15;
  localparam logic [5:0] IDX_HIGH = 6'h16;
  localparam logic [5:0] IDX_STAT = 6'h17;
  localparam logic [5:0] IDX_MASK = 6'h18;
  // control one fields
  localparam int CTL1_PWM_OE = 7;
  localparam int CTL1_PWM_AL = 6;
  localparam int CTL1_MATCH_OE = 5;
  localparam int CTL1_HOSC = 3;
  localparam int CTL1_ONE_SHOT = 2;
  localparam int CTL1_RELOAD = 1;
  localparam int CTL1_ENABLE = 0;
  localparam logic [7:0] CTL1_RMASK = 8'hEF;
  // control two fields
  localparam int CTL2_HALF = 6;
  localparam int CTL2_CS = 5;
  localparam int CTL2_EDGE = 4;
  localparam int CTL2_PS_DIS_N = 3;
  localparam logic [7:0] CTL2_RMASK = 8'h3F;
  // buzzer, high-bit and status fields
  localparam int BUZZ_EN = 7;
  localparam int HIGH_RELOAD_LSB = 4;
  localparam int HIGH_DUTY_LSB = 0;
  localparam logic [7:0] HIGH_RMASK = 8'h33;
  localparam int STAT_UNDERFLOW = 0;
  localparam logic [7:0] STAT_RMASK = 8'h01;
  // values after reset
  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [7:0] RST_CTL2 = 8'h3F;
  localparam logic [7:0] RST_BUZZ = 8'h0F;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [9:0] RST_COUNT = 10'h000;
  localparam logic [7:0] RST_PSCV = 8'h00;
  // counter values
  localparam logic [9:0] COUNT_ZERO = 10'h000;
  localparam logic [9:0] COUNT_ONES = 10'h3FF;
  localparam logic [9:0] COUNT_STEP = 10'h001;
  localparam logic [7:0] PS_STEP = 8'h01;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* design/dtp_sync3.sv */
`timescale 1ns/1ps
module dtp_sync3 (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic q_reg;

  // a change is accepted only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_reg <= s3_reg;
      end
    end
  end

  assign q = q_reg;
  assign rise = ce && (s2_reg == s3_reg) && s3_reg && !q_reg;
  assign fall = ce && (s2_reg == s3_reg) && !s3_reg && q_reg;
endmodule

/* design/dtp_prescaler.sv */
`timescale 1ns/1ps
module dtp_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick_in,
  input wire logic enable,
  input wire logic [2:0] rate,
  output logic [7:0] count,
  output logic tick_out
);
  logic [7:0] count_reg;
  logic [7:0] low_ones;

  // divide by two to the power rate+1: output when bits rate..0 are ones
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_mask
      assign low_ones[i] = (3'(i) > rate) || count_reg[i] || (i == 7 &&
        rate == 3'h7 && count_reg[7]);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= dtp_pkg::RST_PSCV;
    end else if (ce && enable && tick_in) begin
      count_reg <= 8'(count_reg + dtp_pkg::PS_STEP);
    end
  end

  assign count = count_reg;
  assign tick_out = ce && enable && tick_in && (&low_ones);
endmodule

/* design/dtp_down_timer.sv */
`timescale 1ns/1ps
module dtp_down_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_tick,
  input wire logic high_osc_tick,
  input wire logic external_clock_pin,
  input wire logic cmp_out,
  input wire logic cmp_oe,
  input wire logic other_buzzer_out,
  input wire logic other_buzzer_oe,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pwm_pad_out,
  output logic pwm_pad_oe,
  output logic shared_pad_out,
  output logic shared_pad_oe,
  output logic buzzer_pad_out,
  output logic buzzer_pad_oe,
  output logic irq
);
  logic [7:0] ctl1_reg;
  logic [7:0] ctl2_reg;
  logic [7:0] duty_low_reg;
  logic [7:0] buzz_reg;
  logic [7:0] high_reg;
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic [7:0] reload_low_reg;
  logic [9:0] count_reg;
  logic stopped_reg;
  logic toggle_reg;
  logic pwm_raw_reg;
  logic pwm_out_reg;
  logic shared_out_reg;
  logic shared_oe_reg;
  logic buzz_out_reg;
  logic [7:0] aw_idx_reg;
  logic aw_full_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rdata_reg;

  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic src_tick;
  logic ps_enable;
  logic ps_tick;
  logic [7:0] ps_count;
  logic timer_tick;
  logic underflow;
  logic [9:0] reload;
  logic [9:0] duty;
  logic pwm_active;
  logic buzz_sel;
  logic wr_fire;
  logic [5:0] wr_idx;
  logic rd_fire;
  logic [5:0] rd_idx;
  logic [7:0] rd_mux;
  logic rd_hit;
  logic wr_hit;

  dtp_sync3 u_ext_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(external_clock_pin),
    .q(ext_level),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  assign ext_edge = ctl2_reg[dtp_pkg::CTL2_EDGE] ?
    ext_fall : ext_rise;
  always_comb begin
    if (ctl1_reg[dtp_pkg::CTL1_HOSC]) begin
      src_tick = high_osc_tick;
    end else if (ctl2_reg[dtp_pkg::CTL2_CS]) begin
      src_tick = ext_edge;
    end else begin
      src_tick = instr_tick;
    end
  end

  // rate is not guarded; changing it while running may fire an early tick
  assign ps_enable = !ctl2_reg[dtp_pkg::CTL2_PS_DIS_N];
  dtp_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .tick_in(src_tick),
    .enable(ps_enable),
    .rate(ctl2_reg[2:0]),
    .count(ps_count),
    .tick_out(ps_tick)
  );

  assign timer_tick = ps_enable ? ps_tick : src_tick;
  assign reload = {high_reg[dtp_pkg::HIGH_RELOAD_LSB +: 2], reload_low_reg};
  assign duty = {high_reg[dtp_pkg::HIGH_DUTY_LSB +: 2], duty_low_reg};
  assign underflow = ce && timer_tick && ctl1_reg[dtp_pkg::CTL1_ENABLE] &&
    !stopped_reg && count_reg == dtp_pkg::COUNT_ZERO;

  // bus write channel
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign wr_fire = ce && aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_idx = aw_idx_reg[7:2];
  always_comb begin
    case (wr_idx)
      dtp_pkg::IDX_COUNT, dtp_pkg::IDX_CTL1, dtp_pkg::IDX_CTL2,
      dtp_pkg::IDX_DUTY, dtp_pkg::IDX_PSCV, dtp_pkg::IDX_BUZZ,
      dtp_pkg::IDX_HIGH, dtp_pkg::IDX_STAT, dtp_pkg::IDX_MASK: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      aw_idx_reg <= dtp_pkg::RST_ZERO;
      w_full_reg <= 1'b0;
      w_data_reg <= dtp_pkg::RST_ZERO;
      w_strb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dtp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // configuration registers; only byte lane zero carries data
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl1_reg <= dtp_pkg::RST_CTL1;
      ctl2_reg <= dtp_pkg::RST_CTL2;
      duty_low_reg <= dtp_pkg::RST_ZERO;
      buzz_reg <= dtp_pkg::RST_BUZZ;
      high_reg <= dtp_pkg::RST_ZERO;
      mask_reg <= dtp_pkg::RST_ZERO;
      reload_low_reg <= dtp_pkg::RST_ZERO;
    end else if (wr_fire && w_strb_reg) begin
      case (wr_idx)
        dtp_pkg::IDX_CTL1: ctl1_reg <= w_data_reg;
        dtp_pkg::IDX_CTL2: ctl2_reg <= w_data_reg;
        dtp_pkg::IDX_DUTY: duty_low_reg <= w_data_reg;
        dtp_pkg::IDX_BUZZ: buzz_reg <= w_data_reg;
        dtp_pkg::IDX_HIGH: high_reg <= w_data_reg;
        dtp_pkg::IDX_MASK: mask_reg <= w_data_reg & dtp_pkg::STAT_RMASK;
        dtp_pkg::IDX_COUNT: reload_low_reg <= w_data_reg;
        default: begin
        end
      endcase
    end
  end

  // sticky status; a new underflow beats a simultaneous clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= dtp_pkg::RST_ZERO;
    end else if (ce) begin
      if (wr_fire && w_strb_reg && wr_idx == dtp_pkg::IDX_STAT) begin
        status_reg <= status_reg & ~w_data_reg;
      end
      if (underflow) begin
        status_reg[dtp_pkg::STAT_UNDERFLOW] <= 1'b1;
      end
    end
  end
  assign irq = |(status_reg & mask_reg);

  // down counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= dtp_pkg::RST_COUNT;
      stopped_reg <= 1'b0;
    end else if (ce) begin
      if (wr_fire && w_strb_reg && wr_idx == dtp_pkg::IDX_COUNT) begin
        count_reg <= {high_reg[dtp_pkg::HIGH_RELOAD_LSB +: 2],
          w_data_reg};
        stopped_reg <= 1'b0;
      end else if (underflow) begin
        if (ctl1_reg[dtp_pkg::CTL1_ONE_SHOT]) begin
          stopped_reg <= 1'b1;
        end else if (ctl1_reg[dtp_pkg::CTL1_RELOAD]) begin
          count_reg <= reload;
        end else begin
          count_reg <= dtp_pkg::COUNT_ONES;
        end
      end else if (timer_tick && ctl1_reg[dtp_pkg::CTL1_ENABLE] &&
          !stopped_reg) begin
        count_reg <= 10'(count_reg - dtp_pkg::COUNT_STEP);
      end
    end
  end

  // waveform outputs; in reload mode the frame is reload+1 ticks, active while count < duty
  assign pwm_active = duty > count_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      toggle_reg <= 1'b0;
      pwm_raw_reg <= 1'b0;
      pwm_out_reg <= 1'b0;
      shared_out_reg <= 1'b0;
      shared_oe_reg <= 1'b0;
      buzz_out_reg <= 1'b0;
    end else if (ce) begin
      if (underflow) begin
        toggle_reg <= !toggle_reg;
      end
      pwm_raw_reg <= pwm_active;
      // half step can only stretch by one system clock here
      pwm_out_reg <= (pwm_active || (pwm_raw_reg &&
        ctl1_reg[dtp_pkg::CTL1_HOSC] && ctl2_reg[dtp_pkg::CTL2_HALF])) ^
        ctl1_reg[dtp_pkg::CTL1_PWM_AL];
      if (ctl1_reg[dtp_pkg::CTL1_MATCH_OE]) begin
        shared_out_reg <= underflow ? !toggle_reg : toggle_reg;
        shared_oe_reg <= 1'b1;
      end else if (cmp_oe) begin
        shared_out_reg <= cmp_out;
        shared_oe_reg <= 1'b1;
      end else begin
        shared_out_reg <= other_buzzer_out;
        shared_oe_reg <= other_buzzer_oe;
      end
      buzz_out_reg <= buzz_reg[dtp_pkg::BUZZ_EN] && buzz_sel;
    end
  end
  assign buzz_sel = buzz_reg[3] ? count_reg[buzz_reg[2:0]] :
    ps_count[buzz_reg[2:0]];
  assign pwm_pad_out = pwm_out_reg;
  assign pwm_pad_oe = ctl1_reg[dtp_pkg::CTL1_PWM_OE];
  assign shared_pad_out = shared_out_reg;
  assign shared_pad_oe = shared_oe_reg;
  assign buzzer_pad_out = buzz_out_reg;
  assign buzzer_pad_oe = buzz_reg[dtp_pkg::BUZZ_EN];

  // read channel
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};
  assign rd_fire = ce && s_axi_arvalid && !rvalid_reg;
  assign rd_idx = s_axi_araddr[7:2];
  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      dtp_pkg::IDX_COUNT: rd_mux = count_reg[7:0];
      dtp_pkg::IDX_CTL1: rd_mux = ctl1_reg & dtp_pkg::CTL1_RMASK;
      dtp_pkg::IDX_CTL2: rd_mux = ctl2_reg & dtp_pkg::CTL2_RMASK;
      dtp_pkg::IDX_PSCV: rd_mux = ps_count;
      dtp_pkg::IDX_HIGH: rd_mux = high_reg & dtp_pkg::HIGH_RMASK;
      dtp_pkg::IDX_STAT: rd_mux = status_reg;
      dtp_pkg::IDX_MASK: rd_mux = mask_reg;
      dtp_pkg::IDX_DUTY, dtp_pkg::IDX_BUZZ: rd_mux = dtp_pkg::RST_ZERO;
      default: begin
        rd_mux = dtp_pkg::RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= dtp_pkg::RESP_OKAY;
      rdata_reg <= dtp_pkg::RST_ZERO;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  property p_reload;
    @(posedge clk) disable iff (rst)
    (underflow && !wr_fire && ctl1_reg[2:1] == 2'h1) |=>
      count_reg == $past(reload);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_one_shot;
    @(posedge clk) disable iff (rst)
    (underflow && !wr_fire && ctl1_reg[dtp_pkg::CTL1_ONE_SHOT]) |=>
      stopped_reg && count_reg == 10'h000;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("no stop");

  property p_all_ones;
    @(posedge clk) disable iff (rst)
    (underflow && !wr_fire && ctl1_reg[2:1] == 2'h0) |=>
      count_reg == 10'h3FF;
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("no 3FF");

  property p_toggle;
    @(posedge clk) disable iff (rst)
    underflow |=> toggle_reg != $past(toggle_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_shared;
    @(posedge clk) disable iff (rst)
    (ce && ctl1_reg[dtp_pkg::CTL1_MATCH_OE]) ##1 ce |->
      shared_pad_oe && shared_pad_out == toggle_reg;
  endproperty
  a_shared: assert property (p_shared) else $error("pad order");

  property p_polarity;
    @(posedge clk) disable iff (rst)
    (ce && !ctl1_reg[dtp_pkg::CTL1_HOSC] && $stable(ctl1_reg)) |=>
      pwm_pad_out == ($past(pwm_active) ^
        $past(ctl1_reg[dtp_pkg::CTL1_PWM_AL]));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("pwm level");

  // the delayed copy keeps the pad active one clock past the compare
  property p_half_step;
    @(posedge clk) disable iff (rst)
    (ce && ctl1_reg[dtp_pkg::CTL1_HOSC] && ctl2_reg[dtp_pkg::CTL2_HALF] &&
      pwm_raw_reg) |=>
      pwm_pad_out != $past(ctl1_reg[dtp_pkg::CTL1_PWM_AL]);
  endproperty
  a_half_step: assert property (p_half_step) else $error("half");

  property p_ps_read;
    @(posedge clk) disable iff (rst)
    (rd_fire && rd_idx == dtp_pkg::IDX_PSCV) |=>
      s_axi_rvalid && s_axi_rdata[7:0] == $past(ps_count);
  endproperty
  a_ps_read: assert property (p_ps_read) else $error("ps read");

  property p_count_write;
    @(posedge clk) disable iff (rst)
    (wr_fire && w_strb_reg && wr_idx == dtp_pkg::IDX_COUNT) |=>
      count_reg[7:0] == $past(w_data_reg) && !stopped_reg;
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("load");

  property p_buzz_off;
    @(posedge clk) disable iff (rst)
    (ce && !buzz_reg[dtp_pkg::BUZZ_EN]) |=> !buzzer_pad_out;
  endproperty
  a_buzz_off: assert property (p_buzz_off) else $error("buzz on");

  c_underflow: cover property (@(posedge clk) disable iff (rst) underflow);
  c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_ext: cover property (@(posedge clk) disable iff (rst)
    ctl2_reg[dtp_pkg::CTL2_CS] && ext_edge && timer_tick);
  c_ps: cover property (@(posedge clk) disable iff (rst) ps_tick);
endmodule

/* bench/tb_down_timer_pwm_buzzer.sv */
`timescale 1ns/1ps
module tb_down_timer_pwm_buzzer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic instr_tick = 1'b0;
  logic high_osc_tick = 1'b0;
  logic external_clock_pin = 1'b0;
  logic cmp_out = 1'b1;
  logic cmp_oe = 1'b1;
  logic other_buzzer_out = 1'b0;
  logic other_buzzer_oe = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic pwm_pad_out, pwm_pad_oe, shared_pad_out, shared_pad_oe;
  logic buzzer_pad_out, buzzer_pad_oe, irq;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int fails = 0;
  int checks = 0;
  logic [7:0] v;
  logic [7:0] pv;
  int hi_n = 0;
  int base;
  int span[3];
  localparam int T_INSTR = 0;
  localparam int T_HOSC = 1;
  localparam int T_PIN = 2;

  dtp_down_timer uut (
    .clk, .rst, .ce, .instr_tick, .high_osc_tick, .external_clock_pin,
    .cmp_out, .cmp_oe, .other_buzzer_out, .other_buzzer_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pwm_pad_out, .pwm_pad_oe, .shared_pad_out,
    .shared_pad_oe, .buzzer_pad_out, .buzzer_pad_oe, .irq
  );

  always #2 clk = ~clk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({33'h0, got}, {33'h0, exp});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // the response is compared by the monitor, not here
  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er = dtp_pkg::RESP_OKAY);
    bit aw;
    bit w;
    bit ta;
    bit tw;
    bit tb;
    int n;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    bq.push_back(er);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // readies and valids come from registers, so the level seen between
    // edges is the one that the next rising edge takes
    while (!(aw && w) && n < 64) begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge clk);
      n++;
      if (!aw && ta) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && tw) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge clk);
      tb = s_axi_bvalid;
      @(posedge clk);
      n++;
    end while (!tb && n < 64);
    s_axi_bready <= 1'b0;
    if (n >= 64)
      fails++;
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er = dtp_pkg::RESP_OKAY);
    int n;
    bit t;
    n = 0;
    rq.push_back({er, 24'h0, d});
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
      n++;
    end while (!t && n < 64);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
      t = s_axi_rvalid;
      @(posedge clk);
      n++;
    end while (!t && n < 64);
    s_axi_rready <= 1'b0;
    if (n >= 64)
      fails++;
    @(posedge clk);
  endtask

  task automatic drive_tick(input int w, input logic l);
    case (w)
      T_INSTR: instr_tick <= l;
      T_HOSC: high_osc_tick <= l;
      default: external_clock_pin <= l;
    endcase
  endtask

  // pulse input w high for g cycles, low for g cycles, k times
  task automatic tick(input int w, input int k, input int g);
    repeat (k) begin
      drive_tick(w, 1'b1);
      repeat (g) @(posedge clk);
      drive_tick(w, 1'b0);
      repeat (g) @(posedge clk);
    end
  endtask

  // both sides move only after rising edges, so the falling edge shows
  // what the next rising edge hands over
  always @(negedge clk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
  end

  always @(negedge clk) begin
    if (pwm_pad_out)
      hi_n++;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(32'h75e7));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(dtp_pkg::IDX_CTL1, dtp_pkg::RST_CTL1);
    rd(dtp_pkg::IDX_CTL2, dtp_pkg::RST_CTL2);
    rd(dtp_pkg::IDX_BUZZ, 8'h00);
    rd(dtp_pkg::IDX_PSCV, dtp_pkg::RST_PSCV);
    rd(dtp_pkg::IDX_STAT, 8'h00);
    rd(6'h3F, 8'h00, dtp_pkg::RESP_SLVERR);
    wr(6'h3F, 8'h5A, dtp_pkg::RESP_SLVERR);
    $display("test reset done");
    // comparator owns the shared pad until the toggle output is enabled
    chkb(shared_pad_out, 1'b1);
    wr(dtp_pkg::IDX_CTL2, 8'h08);
    wr(dtp_pkg::IDX_COUNT, 8'h01);
    wr(dtp_pkg::IDX_CTL1, 8'h23);
    tick(T_INSTR, 2, 1);
    chkb(shared_pad_oe, 1'b1);
    chkb(shared_pad_out, 1'b1);
    tick(T_INSTR, 2, 1);
    chkb(shared_pad_out, 1'b0);
    $display("test toggle done");
    chkb(irq, 1'b0);
    wr(dtp_pkg::IDX_MASK, 8'h01);
    chkb(irq, 1'b1);
    wr(dtp_pkg::IDX_STAT, 8'h01);
    chkb(irq, 1'b0);
    rd(dtp_pkg::IDX_STAT, 8'h00);
    $display("test irq done");
    wr(dtp_pkg::IDX_CTL1, 8'h03);
    wr(dtp_pkg::IDX_COUNT, 8'h05);
    tick(T_INSTR, 6, 1);
    rd(dtp_pkg::IDX_COUNT, 8'h05);
    tick(T_INSTR, 2, 1);
    rd(dtp_pkg::IDX_COUNT, 8'h03);
    wr(dtp_pkg::IDX_CTL1, 8'h01);
    wr(dtp_pkg::IDX_COUNT, 8'h05);
    tick(T_INSTR, 6, 1);
    rd(dtp_pkg::IDX_COUNT, 8'hFF);
    tick(T_INSTR, 1, 1);
    rd(dtp_pkg::IDX_COUNT, 8'hFE);
    wr(dtp_pkg::IDX_CTL1, 8'h07);
    wr(dtp_pkg::IDX_COUNT, 8'h02);
    tick(T_INSTR, 5, 1);
    rd(dtp_pkg::IDX_COUNT, 8'h00);
    wr(dtp_pkg::IDX_COUNT, 8'h02);
    tick(T_INSTR, 1, 1);
    rd(dtp_pkg::IDX_COUNT, 8'h01);
    // ticks that arrive while the clock enable is low are lost
    wr(dtp_pkg::IDX_CTL1, 8'h03);
    wr(dtp_pkg::IDX_COUNT, 8'h05);
    ce <= 1'b0;
    tick(T_INSTR, 3, 1);
    ce <= 1'b1;
    rd(dtp_pkg::IDX_COUNT, 8'h05);
    tick(T_INSTR, 1, 1);
    rd(dtp_pkg::IDX_COUNT, 8'h04);
    $display("test modes done");
    wr(dtp_pkg::IDX_CTL1, 8'h03);
    wr(dtp_pkg::IDX_CTL2, 8'h38);
    wr(dtp_pkg::IDX_COUNT, 8'h0A);
    tick(T_PIN, 3, 8);
    tick(T_INSTR, 2, 1);
    rd(dtp_pkg::IDX_COUNT, 8'h07);
    wr(dtp_pkg::IDX_CTL2, 8'h28);
    tick(T_PIN, 2, 8);
    rd(dtp_pkg::IDX_COUNT, 8'h05);
    wr(dtp_pkg::IDX_CTL1, 8'h0B);
    tick(T_HOSC, 3, 1);
    tick(T_PIN, 1, 8);
    rd(dtp_pkg::IDX_COUNT, 8'h02);
    $display("test sources done");
    // rate is set while the prescaler is still off
    wr(dtp_pkg::IDX_CTL1, 8'h03);
    wr(dtp_pkg::IDX_CTL2, 8'h09);
    wr(dtp_pkg::IDX_CTL2, 8'h01);
    wr(dtp_pkg::IDX_COUNT, 8'h0A);
    tick(T_INSTR, 8, 1);
    rd(dtp_pkg::IDX_COUNT, 8'h08);
    wr(dtp_pkg::IDX_CTL2, 8'h09);
    // eight source ticks went into the prescaler, which now holds
    pv = 8'h08;
    rd(dtp_pkg::IDX_PSCV, pv);
    $display("test prescaler done");
    wr(dtp_pkg::IDX_CTL1, 8'h80);
    wr(dtp_pkg::IDX_HIGH, 8'h00);
    wr(dtp_pkg::IDX_DUTY, 8'h03);
    wr(dtp_pkg::IDX_COUNT, 8'h08);
    repeat (2) @(posedge clk);
    chkb(pwm_pad_oe, 1'b1);
    chkb(pwm_pad_out, 1'b0);
    wr(dtp_pkg::IDX_CTL1, 8'hC0);
    repeat (2) @(posedge clk);
    chkb(pwm_pad_out, 1'b1);
    wr(dtp_pkg::IDX_COUNT, 8'h02);
    repeat (2) @(posedge clk);
    chkb(pwm_pad_out, 1'b0);
    // high bits reach both the loaded count and the duty compare
    wr(dtp_pkg::IDX_HIGH, 8'h10);
    wr(dtp_pkg::IDX_COUNT, 8'h02);
    repeat (2) @(posedge clk);
    chkb(pwm_pad_out, 1'b1);
    wr(dtp_pkg::IDX_HIGH, 8'h11);
    repeat (2) @(posedge clk);
    chkb(pwm_pad_out, 1'b0);
    wr(dtp_pkg::IDX_HIGH, 8'h00);
    // one pulse each: plain, half step, half step without high oscillator
    for (int h = 0; h < 3; h++) begin
      wr(dtp_pkg::IDX_CTL2, (h == 0) ? 8'h08 : 8'h48);
      wr(dtp_pkg::IDX_CTL1, (h == 2) ? 8'h80 : 8'h88);
      wr(dtp_pkg::IDX_COUNT, 8'h08);
      base = hi_n;
      wr(dtp_pkg::IDX_COUNT, 8'h02);
      wr(dtp_pkg::IDX_COUNT, 8'h08);
      repeat (3) @(posedge clk);
      span[h] = hi_n - base;
    end
    chk(34'(span[1]), 34'(span[0] + 1));
    chk(34'(span[2]), 34'(span[0]));
    wr(dtp_pkg::IDX_CTL1, 8'h00);
    chkb(pwm_pad_oe, 1'b0);
    $display("test pwm done");
    v = 8'($urandom);
    wr(dtp_pkg::IDX_COUNT, v);
    rd(dtp_pkg::IDX_COUNT, v);
    for (int b = 0; b < 16; b++) begin
      wr(dtp_pkg::IDX_BUZZ, 8'h80 | 8'(b));
      repeat (2) @(posedge clk);
      chkb(buzzer_pad_oe, 1'b1);
      if (b > 7)
        chkb(buzzer_pad_out, v[b-8]);
      else
        chkb(buzzer_pad_out, pv[b]);
    end
    wr(dtp_pkg::IDX_BUZZ, 8'h0F);
    repeat (2) @(posedge clk);
    chkb(buzzer_pad_oe, 1'b0);
    chkb(buzzer_pad_out, 1'b0);
    $display("test buzzer done");
    tally_and_finish;
  end
endmodule
